// File: dv/epc_dev_model.sv
/*
 Behavioural model of the 8K x 8 memory, seen through its pins.
 Assumes the bench resolves the byte lines from both enables.
*/
`timescale 1ns/1ps
`default_nettype none
module epc_dev_model
	import epc_pkg::*;
(
	input wire epc_strobes_t strobes,
	input wire logic [EPC_AW-1:0] word_select_lines,
	input wire logic [EPC_DW-1:0] data_in,
	output logic [EPC_DW-1:0] data_out,
	output logic drive,
	output var int pulses,
	output var int pw_ns,
	output var int vpp_hops
);
	logic [EPC_DW-1:0] mem [int];
	int nwr;
	realtime t0;
	initial begin
		pulses = 0;
		pw_ns = 0;
		vpp_hops = 0;
		nwr = 0;
	end
	assign drive = !strobes.chip_sel_n && !strobes.out_gate_n && strobes.program_strobe_n;
	// Erased locations are absent from the sparse array
	always @(word_select_lines, nwr) begin
		data_out = mem.exists(int'(word_select_lines)) ? mem[int'(word_select_lines)] : EPC_ERASED;
	end
	always @(negedge strobes.program_strobe_n) t0 = $realtime;
	always @(posedge strobes.program_strobe_n) begin
		if (!strobes.chip_sel_n && strobes.out_gate_n && strobes.vpp_high) begin
			pw_ns = int'($realtime - t0);
			pulses++;
			mem[int'(word_select_lines)] = data_out & data_in;
			nwr++;
		end
	end
	always @(strobes.vpp_high) begin
		if (!strobes.chip_sel_n && !strobes.program_strobe_n) vpp_hops++;
	end
endmodule : epc_dev_model
`default_nettype wire

// File: dv/epc_host_bench.sv
/*
 Self-checking bench: host controller against the memory model.
 Assumes the nominal fast pulse; slow pulses and failures are too long to run.
*/
`timescale 1ns/1ps
`default_nettype none
module epc_host_bench
	import epc_pkg::*;
;
	logic clock, sys_rst, req_valid, req_ready, resp_valid, resp_fail, oe_n, drive;
	epc_req_t req;
	epc_strobes_t strobes;
	logic [4:0] resp_pulses;
	logic [EPC_AW-1:0] wsl;
	logic [7:0] resp_data, host_o, dev_q, last_q, bus;
	int miscompares, checks, pulses, pw_ns, vpp_hops;
	epc_host dut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp_data(resp_data), .resp_fail(resp_fail), .resp_pulses(resp_pulses),
		.strobes(strobes), .word_select_lines(wsl), .byte_lines_i(bus), .byte_lines_o(host_o),
		.byte_lines_oe_n(oe_n));
	epc_dev_model dev (.strobes(strobes), .word_select_lines(wsl), .data_in(bus), .data_out(dev_q),
		.drive(drive), .pulses(pulses), .pw_ns(pw_ns), .vpp_hops(vpp_hops));
	// A released bus shows the inverse of its last value, never a lucky match
	always @* if (drive === 1'b1) last_q = dev_q;
	assign bus = (oe_n === 1'b0) ? host_o : (drive === 1'b1) ? dev_q : ~last_q;
	task end_sim();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_sim
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
		int n;
		req_valid = 1'b1;
		req = '{write: w, slow: 1'b0, addr: a, data: d};
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			@(posedge clock); #1; n++;
		end
		if (req_ready !== 1'b1) begin
			miscompares++;
			end_sim();
		end
		@(posedge clock); #1;
		req_valid = 1'b0;
		n = 0;
		while (resp_valid !== 1'b1 && n < 20000) begin
			@(posedge clock); #1; n++;
		end
		if (resp_valid !== 1'b1) begin
			miscompares++;
			end_sim();
		end
	endtask : xfer
	task t_read(input logic [12:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		check("read data", {24'h0, resp_data}, {24'h0, exp});
		@(posedge clock); #1;
		check("idle pins", {28'h0, strobes}, 32'h0000000e);
		check("idle enable", {31'h0, oe_n}, 32'h00000001);
	endtask : t_read
	task t_program(input logic [12:0] a, input logic [7:0] d, input logic [7:0] exp);
		int p0;
		p0 = pulses;
		xfer(1'b1, a, d);
		check("prog fail", {31'h0, resp_fail}, 32'h0);
		check("prog pulses", {27'h0, resp_pulses}, 32'h1);
		check("model pulses", pulses - p0, 32'h1);
		check("verify data", {24'h0, resp_data}, {24'h0, exp});
		check("pulse ns", pw_ns, EPC_PW_FAST_CYC * 10);
		check("vpp hops", vpp_hops, 32'h0);
		t_read(a, exp);
	endtask : t_program
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		miscompares = 0;
		checks = 0;
		sys_rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		repeat (3) @(posedge clock);
		#1 sys_rst = 1'b0;
		check("ready", {31'h0, req_ready}, 32'h1);
		t_read(13'h1fff, EPC_ERASED);
		t_program(13'h0000, 8'h5a, 8'h5a);
		t_read(13'h0001, EPC_ERASED);
		t_program(13'h0000, 8'h0a, 8'h0a);
		t_program(13'h1fff, 8'h00, 8'h00);
		end_sim();
	end
endmodule : epc_host_bench
`default_nettype wire

// File: src/epc_host.sv
/*
 Host controller that reads and programs the memory through its pins.
 Assumes an external switch turns vpp_high into the raised supply and that
 the byte lines are resolved from the enable outside this module.
*/
`timescale 1ns/1ps
`default_nettype none
module epc_host
	import epc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire epc_req_t req,
	output logic req_ready,
	output logic resp_valid,
	output logic [EPC_DW-1:0] resp_data,
	output logic resp_fail,
	output logic [4:0] resp_pulses,
	output epc_strobes_t strobes,
	output logic [EPC_AW-1:0] word_select_lines,
	input wire logic [EPC_DW-1:0] byte_lines_i,
	output logic [EPC_DW-1:0] byte_lines_o,
	output logic byte_lines_oe_n
);
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_READ = 7'h02,
		S_VPP = 7'h04,
		S_SETUP = 7'h08,
		S_PULSE = 7'h10,
		S_HOLD = 7'h20,
		S_VERIFY = 7'h40
	} epc_state_t;
	epc_state_t state_q, state_d;
	epc_req_t cur_q;
	logic [4:0] pulses_q;
	logic [EPC_DW-1:0] sync1_q, sync2_q;
	logic [EPC_DW-1:0] resp_data_q;
	logic resp_valid_q, resp_fail_q;
	logic tmr_load, tmr_done;
	logic [EPC_CW-1:0] tmr_val;
	logic take, match, last_pulse;
	logic vpp_on, sel_n, gate_n, strobe_n;
	logic [EPC_CW-1:0] low_cnt_q;
	logic pw_in_window;
	// Synchroniser for the byte lines read back from the device
	always_ff @(posedge clock) begin
		sync1_q <= byte_lines_i;
		sync2_q <= sync1_q;
	end
	assign take = req_valid && state_q == S_IDLE;
	assign req_ready = state_q == S_IDLE;
	// A bit asked to stay one but already zero can never be restored
	assign match = sync2_q == cur_q.data;
	assign last_pulse = pulses_q == 5'(EPC_MAX_PULSES);
	epc_timer u_tmr (
		.clock(clock),
		.sys_rst(sys_rst),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);
	always_comb begin
		state_d = state_q;
		tmr_load = 1'b0;
		tmr_val = EPC_CW'(EPC_SETUP_CYC);
		unique case (state_q)
			S_IDLE: begin
				if (take) begin
					tmr_load = 1'b1;
					if (req.write) begin
						state_d = S_VPP;
					end else begin
						tmr_val = EPC_CW'(EPC_READ_CYC + 2);
						state_d = S_READ;
					end
				end
			end
			S_READ: if (tmr_done) state_d = S_IDLE;
			S_VPP: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					state_d = S_SETUP;
				end
			end
			S_SETUP: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					// The timer holds a state one cycle past its load value
					tmr_val = cur_q.slow ? EPC_CW'(EPC_PW_SLOW_CYC - 1) : EPC_CW'(EPC_PW_FAST_CYC - 1);
					state_d = S_PULSE;
				end
			end
			S_PULSE: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					state_d = S_HOLD;
				end
			end
			S_HOLD: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_val = EPC_CW'(EPC_READ_CYC + 2);
					state_d = S_VERIFY;
				end
			end
			S_VERIFY: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					state_d = (match || last_pulse) ? S_IDLE : S_SETUP;
				end
			end
		endcase
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= S_IDLE;
			cur_q <= '0;
			pulses_q <= '0;
		end else begin
			state_q <= state_d;
			if (take) begin
				cur_q <= req;
				pulses_q <= '0;
			end
			if (state_q == S_SETUP && tmr_done)
				pulses_q <= pulses_q + 5'd1;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			resp_valid_q <= 1'b0;
			resp_fail_q <= 1'b0;
			resp_data_q <= '0;
		end else begin
			resp_valid_q <= 1'b0;
			if (state_q == S_READ && tmr_done) begin
				resp_valid_q <= 1'b1;
				resp_fail_q <= 1'b0;
				resp_data_q <= sync2_q;
			end
			if (state_q == S_VERIFY && tmr_done && (match || last_pulse)) begin
				resp_valid_q <= 1'b1;
				resp_fail_q <= !match;
				resp_data_q <= sync2_q;
			end
		end
	end
	assign resp_valid = resp_valid_q;
	assign resp_fail = resp_fail_q;
	assign resp_data = resp_data_q;
	assign resp_pulses = pulses_q;
	// Supply stays raised across every pulse; strobe is high whenever it changes
	assign vpp_on = state_q inside {S_VPP, S_SETUP, S_PULSE, S_HOLD, S_VERIFY};
	assign sel_n = !(state_q inside {S_READ, S_SETUP, S_PULSE, S_HOLD, S_VERIFY});
	assign gate_n = !(state_q inside {S_READ, S_VERIFY});
	assign strobe_n = state_q != S_PULSE;
	// One driver for the whole pin group, so all strobes move together
	assign strobes = '{chip_sel_n: sel_n, out_gate_n: gate_n, program_strobe_n: strobe_n, vpp_high: vpp_on};
	assign word_select_lines = cur_q.addr;
	assign byte_lines_o = cur_q.data;
	assign byte_lines_oe_n = !(state_q inside {S_SETUP, S_PULSE, S_HOLD});

	// Counts low strobe cycles so the whole width can be judged at its end
	always_ff @(posedge clock) begin
		if (sys_rst || strobes.program_strobe_n)
			low_cnt_q <= '0;
		else
			low_cnt_q <= low_cnt_q + 1'b1;
	end
	assign pw_in_window = cur_q.slow ? (low_cnt_q >= EPC_PW_SLOW_MIN_CYC && low_cnt_q <= EPC_PW_SLOW_MAX_CYC)
		: (low_cnt_q >= EPC_PW_FAST_MIN_CYC && low_cnt_q <= EPC_PW_FAST_MAX_CYC);
	property p_pulse_window;
		@(posedge clock) disable iff (sys_rst)
		$rose(strobes.program_strobe_n) |-> pw_in_window;
	endproperty
	a_pulse_window: assert property (p_pulse_window) else $error("strobe pulse outside window");
	property p_pulse_count;
		@(posedge clock) disable iff (sys_rst)
		resp_valid && cur_q.write |-> resp_pulses != 5'd0;
	endproperty
	a_pulse_count: assert property (p_pulse_count) else $error("program answered without a pulse");
	property p_inhibit;
		@(posedge clock) disable iff (sys_rst)
		strobes.chip_sel_n |-> strobes.program_strobe_n && byte_lines_oe_n;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("activity while deselected");
	property p_verify_gate;
		@(posedge clock) disable iff (sys_rst)
		state_q == S_VERIFY |-> !strobes.chip_sel_n && !strobes.out_gate_n && strobes.program_strobe_n
			&& strobes.vpp_high && byte_lines_oe_n;
	endproperty
	a_verify_gate: assert property (p_verify_gate) else $error("bad verify strobes");
	property p_pulse_width;
		@(posedge clock) disable iff (sys_rst)
		$fell(strobes.program_strobe_n) && !cur_q.slow |-> !strobes.program_strobe_n [*8];
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("strobe pulse too short");
	property p_no_contention;
		@(posedge clock) disable iff (sys_rst)
		!byte_lines_oe_n |-> strobes.out_gate_n;
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("host drives while device may drive");
	property p_vpp_stable;
		@(posedge clock) disable iff (sys_rst)
		!strobes.program_strobe_n |-> $stable(strobes.vpp_high) && strobes.vpp_high;
	endproperty
	a_vpp_stable: assert property (p_vpp_stable) else $error("supply switched during pulse");
	property p_pulse_limit;
		@(posedge clock) disable iff (sys_rst)
		pulses_q <= 5'(EPC_MAX_PULSES);
	endproperty
	a_pulse_limit: assert property (p_pulse_limit) else $error("too many pulses");
	property p_prog_select;
		@(posedge clock) disable iff (sys_rst)
		!strobes.program_strobe_n |-> !strobes.chip_sel_n && strobes.out_gate_n;
	endproperty
	a_prog_select: assert property (p_prog_select) else $error("pulse without select");
	sequence s_verify_end;
		state_q == S_VERIFY && tmr_done && match;
	endsequence
	property p_verify_done;
		@(posedge clock) disable iff (sys_rst)
		s_verify_end |=> resp_valid && !resp_fail;
	endproperty
	a_verify_done: assert property (p_verify_done) else $error("verify pass not reported");
	property p_addr_stable;
		@(posedge clock) disable iff (sys_rst)
		!strobes.program_strobe_n |-> $stable(word_select_lines) && $stable(byte_lines_o);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved in pulse");
	property p_read_gate;
		@(posedge clock) disable iff (sys_rst)
		state_q == S_READ |-> !strobes.chip_sel_n && !strobes.out_gate_n && strobes.program_strobe_n
			&& !strobes.vpp_high;
	endproperty
	a_read_gate: assert property (p_read_gate) else $error("bad read strobes");
endmodule : epc_host
`default_nettype wire

// File: src/epc_pkg.sv
/*
 Constants, types and timing for the host-side controller of an 8K x 8
 one-time programmable read-only memory.
 Assumes a 100 MHz system clock and a device wired pin to pin.
*/
// Overview of operation
// - Select low, gate high, strobe low, raised supply: presented byte is written.
// - Programming mode needs raised supply about 12.75 V and select low.
// - Each pulse needs address and byte presented at logic levels.
// - At 12.75 V each strobe pulse lasts 95 to 105 us, nominal 100 us.
// - Alternatively 12.5 V supply with 1 ms nominal strobe pulses.
// - Each location gets at least one and at most 25 pulses.
// - Never switch programming supply while select and strobe are both low.
package epc_pkg;
	localparam int EPC_AW = 13;
	localparam int EPC_DW = 8;
	localparam logic [EPC_DW-1:0] EPC_ERASED = 8'hff;
	localparam int EPC_CLK_MHZ = 100;
	localparam int EPC_PW_FAST_US = 100;
	localparam int EPC_PW_SLOW_US = 1000;
	localparam int EPC_SETUP_US = 2;
	localparam int EPC_READ_NS = 250;
	localparam int EPC_MAX_PULSES = 25;
	localparam int EPC_PW_FAST_CYC = EPC_PW_FAST_US * EPC_CLK_MHZ;
	localparam int EPC_PW_SLOW_CYC = EPC_PW_SLOW_US * EPC_CLK_MHZ;
	localparam int EPC_PW_FAST_MIN_CYC = 95 * EPC_CLK_MHZ;
	localparam int EPC_PW_FAST_MAX_CYC = 105 * EPC_CLK_MHZ;
	localparam int EPC_PW_SLOW_MIN_CYC = 950 * EPC_CLK_MHZ;
	localparam int EPC_PW_SLOW_MAX_CYC = 1050 * EPC_CLK_MHZ;
	localparam int EPC_SETUP_CYC = EPC_SETUP_US * EPC_CLK_MHZ;
	localparam int EPC_READ_CYC = (EPC_READ_NS * EPC_CLK_MHZ + 999) / 1000;
	localparam int EPC_CW = 17;
	typedef struct packed {
		logic chip_sel_n;
		logic out_gate_n;
		logic program_strobe_n;
		logic vpp_high;
	} epc_strobes_t;
	typedef struct packed {
		logic write;
		logic slow;
		logic [EPC_AW-1:0] addr;
		logic [EPC_DW-1:0] data;
	} epc_req_t;
endpackage : epc_pkg

// File: src/epc_timer.sv
/*
 Down counter that times strobe widths and setup waits.
 Assumes load and count come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module epc_timer
	import epc_pkg::*;
(
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [EPC_CW-1:0] load_val,
	output logic done
);
	logic [EPC_CW-1:0] cnt_q;
	always_ff @(posedge clock) begin
		if (sys_rst)
			cnt_q <= '0;
		else if (load)
			cnt_q <= load_val;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end
	// Done must not look at load: the caller derives load from done
	assign done = cnt_q == '0;
endmodule : epc_timer
`default_nettype wire
